// ===== common/rds_defines.vh
`ifndef RDS_DEFINES_VH
`define RDS_DEFINES_VH

// Nominal input range codes.
`define RDS_TYPE_I020   3'h0
`define RDS_TYPE_I420   3'h1
`define RDS_TYPE_U010   3'h2
`define RDS_TYPE_U210   3'h3
`define RDS_TYPE_U05    3'h4
`define RDS_TYPE_U15    3'h5

// Range start and width in thousandths of a mA or V.
`define RDS_START_4MA   32'h0000_0FA0
`define RDS_WIDTH_16MA  32'h0000_3E80
`define RDS_WIDTH_20MA  32'h0000_4E20
`define RDS_WIDTH_10V   32'h0000_2710
`define RDS_START_2V    32'h0000_07D0
`define RDS_WIDTH_8V    32'h0000_1F40
`define RDS_WIDTH_5V    32'h0000_1388
`define RDS_START_1V    32'h0000_03E8
`define RDS_WIDTH_4V    32'h0000_0FA0

// Conversion curve codes.
`define RDS_CURVE_LIN   2'h0
`define RDS_CURVE_SQR   2'h1
`define RDS_CURVE_ROOT  2'h2
`define RDS_CURVE_USER  2'h3

// Arithmetic constants.
`define RDS_PERMILLE    32'h0000_03E8
`define RDS_X_SCALE     12'h3E8
`define RDS_FRAC_BITS   16
`define RDS_Q_HALF      17'h0_8000
`define RDS_DISP_MIN    16'hFC19
`define RDS_DISP_MAX    16'h270F
`define RDS_MIN_PTS     5'h02
`define RDS_NUM_PTS     5'h14
`define RDS_DIV_STEPS   6'h38
`define RDS_SQRT_STEPS  6'h16

`endif

// ===== design/rds_point_mem.v
`include "rds_defines.vh"

module rds_point_mem (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        rst_s_n,
  // Write port.
  input  wire        wr_en,
  input  wire [4:0]  wr_idx,
  input  wire [26:0] wr_data,
  // Read port, data one cycle after the address.
  input  wire [4:0]  rd_idx,
  output reg  [26:0] rd_data_r
);

  reg [26:0] mem [0:19];

  always @(posedge core_clk) begin
    if (wr_en && (wr_idx < `RDS_NUM_PTS)) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always @(posedge core_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rd_data_r <= 27'h000_0000;
    end else if (rd_idx < `RDS_NUM_PTS) begin
      rd_data_r <= mem[rd_idx];
    end else begin
      rd_data_r <= 27'h000_0000;
    end
  end

endmodule // rds_point_mem

// ===== design/rds_scaler.v
// Overview of operation
// - Fraction is input minus range start, divided by range width.
// - Values beyond nominal range give fractions outside zero to one.
// - Linear: fraction times (high minus low scale) plus low scale.
// - Low scale above high scale inverts the slope, same arithmetic.
// - Square: squared fraction, then linear scaling and offset.
// - Square root: rooted fraction, then linear scaling and offset.
// - Square root with negative fraction shows exactly the low scale.
// - User curve of 2 to 20 points; bracketing segment is chosen.
// - Segment: fraction times 1000 minus X, times Y slope over X, plus Y.
// - Outside the point span the outermost segment extrapolates.
// - Alarm lit while input is outside the permissible range.
// - Zero-based ranges have a lower permissible border of zero.
// - Beyond permissible range an under or over warning replaces value.
// - Result outside -999 to 9999 gives an excess warning.
// - User curve with under 2 points gives a curve warning.
`include "rds_defines.vh"

module rds_scaler (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        rst_n,
  // Measurement from the converter, thousandths of mA or V.
  input  wire        meas_valid,
  input  wire [17:0] meas_value,
  output wire        meas_ready,
  // Configuration.
  input  wire [2:0]  input_type,
  input  wire [1:0]  curve_sel,
  input  wire [14:0] low_scale_value,
  input  wire [14:0] high_scale_value,
  input  wire [9:0]  low_range_extension,
  input  wire [7:0]  high_range_extension,
  input  wire [4:0]  pt_count,
  // User curve point write.
  input  wire        pt_wr_en,
  input  wire [4:0]  pt_wr_idx,
  input  wire [11:0] pt_wr_x,
  input  wire [14:0] pt_wr_y,
  // Results.
  output reg         result_valid_r,
  output reg  [14:0] disp_value_r,
  output reg         under_range_warning_r,
  output reg         over_range_warning_r,
  output reg         excess_warning_r,
  output reg         curve_warning_r,
  output reg         alarm_indicator_r
);

  localparam S_IDLE  = 3'h0;
  localparam S_DIV   = 3'h1;
  localparam S_SHAPE = 3'h2;
  localparam S_SQRT  = 3'h3;
  localparam S_SCANW = 3'h4;
  localparam S_SCAN  = 3'h5;
  localparam S_LIN   = 3'h6;
  localparam S_OUT   = 3'h7;

  reg  [1:0]         rst_sync_r;
  wire               rst_s_n = rst_sync_r[1];

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  reg  [2:0]         state_r;
  reg  [31:0]        rng_start;
  reg  [31:0]        rng_width;
  reg  [55:0]        dv_num_r;
  reg  [32:0]        dv_rem_r;
  reg  [31:0]        dv_den_r;
  reg  [5:0]         dv_cnt_r;
  reg                dv_neg_r;
  reg                seg_phase_r;
  reg  signed [27:0] frac_r;
  reg  signed [27:0] src_r;
  reg  [21:0]        root_r;
  reg  signed [31:0] w_r;
  reg  signed [14:0] low_r;
  reg  signed [15:0] span_r;
  reg  [1:0]         curve_r;
  reg  [4:0]         cnt_r;
  reg                cw_r;
  reg  [4:0]         idx_r;
  reg  signed [11:0] lo_x_r;
  reg  signed [14:0] lo_y_r;
  wire [26:0]        rd_data;

  rds_point_mem u_mem (
    .core_clk  (core_clk),
    .rst_s_n   (rst_s_n),
    .wr_en     (pt_wr_en),
    .wr_idx    (pt_wr_idx),
    .wr_data   ({pt_wr_x, pt_wr_y}),
    .rd_idx    (idx_r),
    .rd_data_r (rd_data)
  );

  wire signed [11:0] mem_x = rd_data[26:15];
  wire signed [14:0] mem_y = rd_data[14:0];

  always @* begin
    case (input_type)
      `RDS_TYPE_I420: begin
        rng_start = `RDS_START_4MA;
        rng_width = `RDS_WIDTH_16MA;
      end
      `RDS_TYPE_U010: begin
        rng_start = 32'h0000_0000;
        rng_width = `RDS_WIDTH_10V;
      end
      `RDS_TYPE_U210: begin
        rng_start = `RDS_START_2V;
        rng_width = `RDS_WIDTH_8V;
      end
      `RDS_TYPE_U05: begin
        rng_start = 32'h0000_0000;
        rng_width = `RDS_WIDTH_5V;
      end
      `RDS_TYPE_U15: begin
        rng_start = `RDS_START_1V;
        rng_width = `RDS_WIDTH_4V;
      end
      default: begin
        rng_start = 32'h0000_0000;
        rng_width = `RDS_WIDTH_20MA;
      end
    endcase
  end

  wire signed [31:0] meas_ext = {{14{meas_value[17]}}, meas_value};
  wire signed [31:0] meas_k   = meas_ext * $signed(`RDS_PERMILLE);
  wire [31:0] lo_b = rng_start *
                     (`RDS_PERMILLE - {22'h00_0000, low_range_extension});
  wire [31:0] hi_b = (rng_start + rng_width) *
                     (`RDS_PERMILLE + {24'h00_0000, high_range_extension});
  wire is_under = (rng_start == 32'h0000_0000) ? meas_value[17] :
                  (meas_k < $signed(lo_b));
  wire is_over  = meas_k > $signed(hi_b);
  wire signed [31:0] diff = meas_ext - $signed(rng_start);
  wire [31:0] diff_mag = diff[31] ? (32'h0000_0000 - diff) : diff;

  wire [32:0] rem_sh = {dv_rem_r[31:0], dv_num_r[55]};
  wire        rem_ge = rem_sh >= {1'b0, dv_den_r};
  wire        rnd_up = {dv_rem_r[31:0], 1'b0} >= {1'b0, dv_den_r};
  wire [55:0] q_rnd  = dv_num_r + {55'h00_0000_0000_0000, rnd_up};
  wire signed [31:0] q_sig = dv_neg_r ? -$signed(q_rnd[31:0]) :
                                         $signed(q_rnd[31:0]);

  wire signed [55:0] sq_prod = frac_r * frac_r + $signed(`RDS_Q_HALF);
  wire signed [43:0] lin_prod = src_r * span_r + $signed(`RDS_Q_HALF);
  wire signed [43:0] lin_res  = (lin_prod >>> `RDS_FRAC_BITS) + low_r;
  wire [32:0] rem4  = {dv_rem_r[30:0], dv_num_r[55:54]};
  wire [32:0] trial = {9'h000, root_r, 2'b01};

  // fraction in tenths of a percent
  wire signed [39:0] fx = frac_r * $signed({1'b0, `RDS_X_SCALE});
  wire signed [40:0] seg_d = fx - $signed({lo_x_r, 16'h0000});
  wire signed [15:0] ydiff = mem_y - lo_y_r;
  wire signed [55:0] seg_num = seg_d * ydiff;
  wire [55:0] seg_mag = seg_num[55] ? (56'h00_0000_0000_0000 - seg_num) :
                                      seg_num;
  wire [12:0] xdiff = {mem_x[11], mem_x} - {lo_x_r[11], lo_x_r};

  assign meas_ready = rst_s_n && (state_r == S_IDLE);

  always @(posedge core_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      state_r               <= S_IDLE;
      dv_num_r              <= 56'h00_0000_0000_0000;
      dv_rem_r              <= 33'h0_0000_0000;
      dv_den_r              <= 32'h0000_0000;
      dv_cnt_r              <= 6'h00;
      dv_neg_r              <= 1'b0;
      seg_phase_r           <= 1'b0;
      frac_r                <= 28'h000_0000;
      src_r                 <= 28'h000_0000;
      root_r                <= 22'h00_0000;
      w_r                   <= 32'h0000_0000;
      low_r                 <= 15'h0000;
      span_r                <= 16'h0000;
      curve_r               <= `RDS_CURVE_LIN;
      cnt_r                 <= 5'h00;
      cw_r                  <= 1'b0;
      idx_r                 <= 5'h00;
      lo_x_r                <= 12'h000;
      lo_y_r                <= 15'h0000;
      result_valid_r        <= 1'b0;
      disp_value_r          <= 15'h0000;
      under_range_warning_r <= 1'b0;
      over_range_warning_r  <= 1'b0;
      excess_warning_r      <= 1'b0;
      curve_warning_r       <= 1'b0;
      alarm_indicator_r     <= 1'b0;
    end else begin
      result_valid_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (meas_valid) begin
            low_r   <= low_scale_value;
            span_r  <= {high_scale_value[14], high_scale_value} -
                       {low_scale_value[14], low_scale_value};
            curve_r <= curve_sel;
            cnt_r   <= pt_count;
            cw_r    <= 1'b0;
            alarm_indicator_r <= is_under || is_over;
            if (is_under || is_over) begin
              under_range_warning_r <= is_under;
              over_range_warning_r  <= is_over;
              excess_warning_r      <= 1'b0;
              curve_warning_r       <= 1'b0;
              result_valid_r        <= 1'b1;
            end else begin
              dv_num_r    <= {8'h00, diff_mag, 16'h0000};
              dv_den_r    <= rng_width;
              dv_rem_r    <= 33'h0_0000_0000;
              dv_neg_r    <= diff[31];
              dv_cnt_r    <= `RDS_DIV_STEPS;
              seg_phase_r <= 1'b0;
              state_r     <= S_DIV;
            end
          end
        end
        S_DIV: begin
          if (dv_cnt_r == 6'h00) begin
            if (seg_phase_r) begin
              w_r     <= q_sig + lo_y_r;
              state_r <= S_OUT;
            end else begin
              frac_r  <= q_sig[27:0];
              state_r <= S_SHAPE;
            end
          end else begin
            dv_rem_r <= rem_ge ? (rem_sh - {1'b0, dv_den_r}) : rem_sh;
            dv_num_r <= {dv_num_r[54:0], rem_ge};
            dv_cnt_r <= dv_cnt_r - 6'h01;
          end
        end
        S_SHAPE: begin
          case (curve_r)
            `RDS_CURVE_SQR: begin
              src_r   <= sq_prod[43:16];
              state_r <= S_LIN;
            end
            `RDS_CURVE_ROOT: begin
              if (frac_r[27]) begin
                src_r   <= 28'h000_0000;
                state_r <= S_LIN;
              end else begin
                dv_num_r <= {frac_r, 16'h0000, 12'h000};
                dv_rem_r <= 33'h0_0000_0000;
                root_r   <= 22'h00_0000;
                dv_cnt_r <= `RDS_SQRT_STEPS;
                state_r  <= S_SQRT;
              end
            end
            `RDS_CURVE_USER: begin
              if (cnt_r < `RDS_MIN_PTS) begin
                cw_r    <= 1'b1;
                state_r <= S_OUT;
              end else begin
                idx_r   <= 5'h00;
                state_r <= S_SCANW;
              end
            end
            default: begin
              src_r   <= frac_r;
              state_r <= S_LIN;
            end
          endcase
        end
        S_SQRT: begin
          if (dv_cnt_r == 6'h00) begin
            src_r   <= {6'h00, root_r};
            state_r <= S_LIN;
          end else begin
            if (rem4 >= trial) begin
              dv_rem_r <= rem4 - trial;
              root_r   <= {root_r[20:0], 1'b1};
            end else begin
              dv_rem_r <= rem4;
              root_r   <= {root_r[20:0], 1'b0};
            end
            dv_num_r <= {dv_num_r[53:0], 2'b00};
            dv_cnt_r <= dv_cnt_r - 6'h01;
          end
        end
        S_SCANW: begin
          state_r <= S_SCAN;
        end
        S_SCAN: begin
          if (idx_r == 5'h00) begin
            lo_x_r  <= mem_x;
            lo_y_r  <= mem_y;
            idx_r   <= 5'h01;
            state_r <= S_SCANW;
          end else if ((fx <= $signed({mem_x, 16'h0000})) ||
                       (idx_r == cnt_r - 5'h01)) begin
            dv_num_r    <= seg_mag;
            dv_den_r    <= {3'h0, xdiff, 16'h0000};
            dv_rem_r    <= 33'h0_0000_0000;
            dv_neg_r    <= seg_num[55];
            dv_cnt_r    <= `RDS_DIV_STEPS;
            seg_phase_r <= 1'b1;
            state_r     <= S_DIV;
          end else begin
            lo_x_r  <= mem_x;
            lo_y_r  <= mem_y;
            idx_r   <= idx_r + 5'h01;
            state_r <= S_SCANW;
          end
        end
        S_LIN: begin
          w_r     <= lin_res[31:0];
          state_r <= S_OUT;
        end
        S_OUT: begin
          under_range_warning_r <= 1'b0;
          over_range_warning_r  <= 1'b0;
          curve_warning_r       <= cw_r;
          excess_warning_r      <= !cw_r &&
                                   ((w_r < $signed(`RDS_DISP_MIN)) ||
                                    (w_r > $signed(`RDS_DISP_MAX)));
          if (!cw_r && (w_r >= $signed(`RDS_DISP_MIN)) &&
              (w_r <= $signed(`RDS_DISP_MAX))) begin
            disp_value_r <= w_r[14:0];
          end
          result_valid_r <= 1'b1;
          state_r        <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule // rds_scaler

// ===== tb/rds_adc_model.sv
module rds_adc_model (
  // Clock and handshake.
  input  wire logic        core_clk,
  input  wire logic        meas_ready,
  // Sample towards the scaler.
  output logic             meas_valid,
  output logic [17:0]      meas_value
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    meas_valid = 1'b0;
    meas_value = 18'h0_0000;
  end

  // Waits for ready after some idle cycles, then strobes once.
  task automatic send(input logic [17:0] v, input int idle);
    repeat (idle) @(posedge core_clk);
    @(negedge core_clk);
    while (!meas_ready) @(negedge core_clk);
    poke(v);
  endtask

  // Strobes without looking at ready; the value line is scrambled after.
  task automatic poke(input logic [17:0] v);
    @(posedge core_clk);
    meas_valid <= 1'b1;
    meas_value <= v;
    @(posedge core_clk);
    meas_valid <= 1'b0;
    meas_value <= ~v;
  endtask
endmodule // rds_adc_model

// ===== tb/rds_scaler_sva.sv
module rds_scaler_sva (
  // Clock and reset.
  input logic        core_clk,
  input logic        rst_n,
  // Sample handshake.
  input logic        meas_valid,
  input logic [17:0] meas_value,
  input logic        meas_ready,
  // Configuration.
  input logic [2:0]  input_type,
  input logic [1:0]  curve_sel,
  input logic [14:0] low_scale_value,
  input logic [4:0]  pt_count,
  // Results.
  input logic        result_valid_r,
  input logic [14:0] disp_value_r,
  input logic        under_range_warning_r,
  input logic        over_range_warning_r,
  input logic        excess_warning_r,
  input logic        curve_warning_r,
  input logic        alarm_indicator_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [16:0] st;
  logic [1:0]  cap_crv;
  logic [14:0] cap_lo;
  logic        cap_zb;
  logic        cap_sneg;
  logic        cap_neg;
  logic        cap_ats;
  logic        cap_few;
  wire         oor = under_range_warning_r | over_range_warning_r;
  wire         flg = oor | excess_warning_r | curve_warning_r;
  wire         take = meas_valid & meas_ready;

  always @* begin
    case (input_type)
      3'h1: st = 17'h0_0FA0;
      3'h3: st = 17'h0_07D0;
      3'h5: st = 17'h0_03E8;
      default: st = 17'h0_0000;
    endcase
  end

  // Keeps what the accepted sample implies for its result.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_crv <= 2'h0;
      cap_lo <= 15'h0000;
      cap_zb <= 1'b0;
      cap_sneg <= 1'b0;
      cap_neg <= 1'b0;
      cap_ats <= 1'b0;
      cap_few <= 1'b0;
    end else if (take) begin
      cap_crv <= curve_sel;
      cap_lo <= low_scale_value;
      cap_zb <= (st == 17'h0_0000);
      cap_sneg <= meas_value[17];
      cap_neg <= $signed(meas_value) < $signed({1'b0, st});
      cap_ats <= (meas_value == {1'b0, st});
      cap_few <= (pt_count < 5'h02);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_ALARM_EQ: assert property (
    result_valid_r |-> alarm_indicator_r == oor)
    else $error("alarm differs from range flags");
  AST_ONE_FLAG: assert property (
    result_valid_r |-> $onehot0({oor, excess_warning_r, curve_warning_r}))
    else $error("more than one warning");
  AST_OOR_NEXT: assert property (
    result_valid_r && oor |-> $past(take))
    else $error("range warning not one cycle after sample");
  AST_WARN_HOLD: assert property (
    result_valid_r && flg |-> $stable(disp_value_r))
    else $error("value changed on a warning");
  AST_DISP_SPAN: assert property (
    result_valid_r && !flg |-> $signed(disp_value_r) >= -999 &&
      $signed(disp_value_r) <= 9999)
    else $error("shown value outside display span");
  AST_ROOT_NEG: assert property (
    result_valid_r && cap_crv == 2'h2 && cap_neg && !oor |->
      disp_value_r == cap_lo)
    else $error("root of negative fraction not low scale");
  AST_LIN_START: assert property (
    result_valid_r && cap_crv == 2'h0 && cap_ats |->
      !flg && disp_value_r == cap_lo)
    else $error("range start not shown as low scale");
  AST_ZERO_UNDER: assert property (
    result_valid_r && cap_zb |-> under_range_warning_r == cap_sneg)
    else $error("zero based lower border wrong");
  AST_CURVE_FEW: assert property (
    result_valid_r && cap_crv == 2'h3 && cap_few && !oor |->
      curve_warning_r)
    else $error("curve warning missing");
  AST_LIN_TIME: assert property (
    take && curve_sel == 2'h0 |->
      (##1 result_valid_r) or (##61 result_valid_r))
    else $error("linear result late or early");
  AST_READY_OUT: assert property (
    result_valid_r |-> meas_ready)
    else $error("not ready after a result");
  AST_BUSY_TAKE: assert property (
    take |=> !meas_ready || result_valid_r)
    else $error("ready while a sample is converting");
endmodule // rds_scaler_sva

// ===== tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  input_type = 3'h0;
  logic [1:0]  curve_sel = 2'h0;
  logic [14:0] low_scale_value = 15'h0000;
  logic [14:0] high_scale_value = 15'h0000;
  logic [9:0]  low_range_extension = 10'h000;
  logic [7:0]  high_range_extension = 8'h00;
  logic [4:0]  pt_count = 5'h00;
  logic        pt_wr_en = 1'b0;
  logic [4:0]  pt_wr_idx = 5'h00;
  logic [11:0] pt_wr_x = 12'h000;
  logic [14:0] pt_wr_y = 15'h0000;
  wire         meas_valid;
  wire  [17:0] meas_value;
  wire         meas_ready;
  wire         result_valid_r;
  wire  [14:0] disp_value_r;
  wire         under_range_warning_r;
  wire         over_range_warning_r;
  wire         excess_warning_r;
  wire         curve_warning_r;
  wire         alarm_indicator_r;
  int px[6] = '{0, 100, 300, 400, 900, 1000};
  int py[6] = '{-50, -30, 30, 80, 900, 820};
  int sta[8] = '{0, 4000, 0, 2000, 0, 1000, 0, 0};
  int wda[8] = '{20000, 16000, 10000, 8000, 5000, 4000, 20000, 20000};
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int lastw = 0;
  int n;
  int t;

  rds_scaler dut_u (.*);
  rds_adc_model adc_u (.*);

  initial forever #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chkf(input logic [5:0] e, input logic [5:0] s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR flags exp %b got %b", e, s);
    end
  endtask

  task automatic chkv(input int e, input logic [14:0] s);
    cmp_count++;
    if ($isunknown(s) || e - $signed(s) > 1 || $signed(s) - e > 1) begin
      error_cnt++;
      $display("ERROR value exp %0d got %0d", e, $signed(s));
    end
  endtask

  // Result kind: 0 value, 1 under, 2 over, 3 excess, 4 curve.
  function automatic int expk(input int v, output int w);
    real f, s;
    int st, wd, i, lo, hi, lx, hx;
    st = sta[input_type];
    wd = wda[input_type];
    lo = $signed(low_scale_value);
    hi = $signed(high_scale_value);
    lx = low_range_extension;
    hx = high_range_extension;
    w = 0;
    s = 0.0;
    if (st == 0 ? v < 0 : v * 1000 < st * (1000 - lx)) return 1;
    if (v * 1000 > (st + wd) * (1000 + hx)) return 2;
    f = real'(v - st) / wd;
    case (curve_sel)
      2'h0: s = f * (hi - lo) + lo;
      2'h1: s = f * f * (hi - lo) + lo;
      2'h2: s = (f < 0) ? lo : $sqrt(f) * (hi - lo) + lo;
      default: begin
        if (pt_count < 2) return 4;
        i = 1;
        while (i < int'(pt_count) - 1 && f * 1000 > px[i]) i++;
        s = (f * 1000 - px[i-1]) * (py[i] - py[i-1]) / (px[i] - px[i-1]);
        s = s + py[i-1];
      end
    endcase
    w = int'($floor(s + 0.5));
    return (w < -999 || w > 9999) ? 3 : 0;
  endfunction

  task automatic cfg(input int ty, c, lo, hi, lx, hx, np);
    @(posedge core_clk);
    input_type <= ty[2:0];
    curve_sel <= c[1:0];
    low_scale_value <= lo[14:0];
    high_scale_value <= hi[14:0];
    low_range_extension <= lx[9:0];
    high_range_extension <= hx[7:0];
    pt_count <= np[4:0];
  endtask

  task automatic run(input int v, input int idle);
    int k, w, m;
    adc_u.send(v[17:0], idle);
    k = expk(v, w);
    m = 0;
    @(negedge core_clk);
    while (result_valid_r !== 1'b1 && m < 300) begin
      @(negedge core_clk);
      m++;
    end
    if (k == 0) lastw = w;
    chkf({1'b1, k == 1 || k == 2, k == 1, k == 2, k == 3, k == 4},
         {result_valid_r, alarm_indicator_r, under_range_warning_r,
          over_range_warning_r, excess_warning_r,
          curve_warning_r});
    chkv(lastw, disp_value_r);
  endtask

  initial begin
    void'($urandom(76));
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int j = 0; j < 6; j++) begin
      @(posedge core_clk);
      pt_wr_en <= 1'b1;
      pt_wr_idx <= j[4:0];
      pt_wr_x <= px[j][11:0];
      pt_wr_y <= py[j][14:0];
    end
    @(posedge core_clk);
    pt_wr_en <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      cfg(1, c, -300, 1200, 500, 50, 6);
      run(10000, 0);
      run(2500, 1);
      run(20500, 2);
      run(4000, 0);
    end
    cfg(1, 0, 1200, -300, 500, 50, 6);
    run(10000, 0);
    run(2500, 0);
    cfg(1, 0, 0, 1000, 200, 100, 6);
    run(3200, 0);
    run(3199, 0);
    run(22000, 0);
    run(22001, 0);
    run(22001, 0);
    cfg(0, 0, 0, 1000, 999, 0, 6);
    run(0, 0);
    run(-1, 0);
    cfg(1, 0, -999, 9999, 500, 50, 6);
    run(20500, 0);
    run(2500, 0);
    cfg(1, 3, 0, 0, 0, 0, 1);
    run(10000, 0);
    cfg(1, 0, 0, 1000, 0, 0, 6);
    fork
      run(10000, 0);
      begin
        repeat (20) @(posedge core_clk);
        adc_u.poke(18'h0_0000);
      end
    join
    n = 0;
    repeat (80) begin
      @(negedge core_clk);
      if (result_valid_r === 1'b1) n++;
    end
    chkv(0, n[14:0]);
    repeat (40) begin
      t = $urandom % 6;
      cfg(t, $urandom % 4, $urandom_range(9600) - 800,
          $urandom_range(9600) - 800, $urandom_range(999),
          $urandom_range(199), 2 + $urandom_range(4));
      run(sta[t] - wda[t] / 8 + $urandom_range(wda[t] * 5 / 4),
          $urandom_range(3));
    end
    conclude();
  end
endmodule // testbench

bind rds_scaler rds_scaler_sva chk_u (
  .core_clk              (core_clk),
  .rst_n                 (rst_n),
  .meas_valid            (meas_valid),
  .meas_value            (meas_value),
  .meas_ready            (meas_ready),
  .input_type            (input_type),
  .curve_sel             (curve_sel),
  .low_scale_value       (low_scale_value),
  .pt_count              (pt_count),
  .result_valid_r        (result_valid_r),
  .disp_value_r          (disp_value_r),
  .under_range_warning_r (under_range_warning_r),
  .over_range_warning_r  (over_range_warning_r),
  .excess_warning_r      (excess_warning_r),
  .curve_warning_r       (curve_warning_r),
  .alarm_indicator_r     (alarm_indicator_r)
);
